// ---- logic/csics_channel.sv ----
/*
  serial channel start and status block: three-wire master, 8-bit frames, MSB first,
  clock idle high, data changed on the falling edge and sampled on the rising edge.
  assumes a register master that strobes one cycle at a time, and a serial peer on sck/so/si.
*/
// What this block does
// - transfer-end request flag sits at bit 5 of the request flag register.
// - mask bit 5 of the mask register; 0 lets the request through, 1 blocks.
// - writing 1 to start bit 0 sets operation enable, channel waits for data.
// - the start register always reads as zero.
// - status bit 6 reads 1 while a transfer runs, else 0.
// - a write to the low data byte in communication-wait state starts shifting that byte out.
// - at transfer end the shifted-in byte lands in data, request raised.
`default_nettype none

module csics_channel
  import csics_pkg::*;
(
  input  wire logic              core_clk, // 100 MHz core clock
  input  wire logic              arst_n,   // async reset, active low
  input  wire logic              clk_en,   // freezes all state while low
  input  wire csics_bus_req_type bus_req,  // register port request
  output logic [15:0]            rdata,    // read data, cycle after read strobe
  output logic                   sck_o,    // serial clock to peer
  output logic                   so_o,     // serial data to peer
  input  wire logic              si_i,     // serial data from peer
  output logic                   irq_o     // transfer-end interrupt, level
);

  csics_state_type st_reg;
  csics_state_type st_next;

  logic wr_flags;
  logic wr_mask;
  logic wr_start;
  logic wr_stop;
  logic wr_data;
  logic kick;
  logic done;

  // register write decode
  assign wr_flags = bus_req.wr && (bus_req.addr == CSICS_OFS_IRQ_FLAGS);
  assign wr_mask  = bus_req.wr && (bus_req.addr == CSICS_OFS_IRQ_MASK);
  assign wr_start = bus_req.wr && (bus_req.addr == CSICS_OFS_START);
  assign wr_stop  = bus_req.wr && (bus_req.addr == CSICS_OFS_STOP);
  assign wr_data  = bus_req.wr && (bus_req.addr == CSICS_OFS_DATA);

  // a data write starts a frame only in communication-wait state
  assign kick = wr_data && st_reg.op_en && !st_reg.busy;

  // last high half of the eighth bit has run out
  assign done = (st_reg.phase == CSICS_HIGH) && (st_reg.half_cnt == 4'h0)
                && (st_reg.bit_cnt == CSICS_FRAME_BITS);

  // next-state logic
  always_comb begin
    st_next = st_reg;

    // two-flop synchroniser on the serial input
    st_next.si_meta = si_i;
    st_next.si_sync = st_reg.si_meta;

    // start trigger sets operation enable, stop trigger clears it
    if (wr_start && bus_req.wdata[CSICS_START_BIT]) begin
      st_next.op_en = 1'b1;
    end else if (wr_stop && bus_req.wdata[CSICS_START_BIT]) begin
      st_next.op_en = 1'b0;
    end

    // mask register, bit 5 only
    if (wr_mask) begin
      st_next.mask = bus_req.wdata[CSICS_MASK_BIT];
    end

    // write-one clears the request flag
    if (wr_flags && bus_req.wdata[CSICS_FLAG_BIT]) begin
      st_next.flag = 1'b0;
    end

    // shifter
    unique case (st_reg.phase)
      CSICS_IDLE: begin
        if (kick) begin
          st_next.data     = bus_req.wdata[7:0];
          st_next.shift    = bus_req.wdata[7:0];
          st_next.so       = bus_req.wdata[7];
          st_next.sck      = 1'b0;
          st_next.busy     = 1'b1;
          st_next.half_cnt = CSICS_HALF_CYC - 4'h1;
          st_next.bit_cnt  = 4'h0;
          st_next.phase    = CSICS_LOW;
        end else if (wr_data) begin
          st_next.data = bus_req.wdata[7:0];
        end
      end
      CSICS_LOW: begin
        if (st_reg.half_cnt == 4'h0) begin
          // rising edge: sample the peer
          st_next.sck      = 1'b1;
          st_next.shift    = {st_reg.shift[6:0], st_reg.si_sync};
          st_next.bit_cnt  = st_reg.bit_cnt + 4'h1;
          st_next.half_cnt = CSICS_HALF_CYC - 4'h1;
          st_next.phase    = CSICS_HIGH;
        end else begin
          st_next.half_cnt = st_reg.half_cnt - 4'h1;
        end
      end
      CSICS_HIGH: begin
        if (done) begin
          // frame over: received byte into data, raise request
          st_next.data  = st_reg.shift;
          st_next.flag  = 1'b1;
          st_next.busy  = 1'b0;
          st_next.so    = 1'b1;
          st_next.phase = CSICS_IDLE;
        end else if (st_reg.half_cnt == 4'h0) begin
          // falling edge: present the next bit
          st_next.sck      = 1'b0;
          st_next.so       = st_reg.shift[7];
          st_next.half_cnt = CSICS_HALF_CYC - 4'h1;
          st_next.phase    = CSICS_LOW;
        end else begin
          st_next.half_cnt = st_reg.half_cnt - 4'h1;
        end
      end
      default: begin
        st_next.phase = CSICS_IDLE;
        st_next.busy  = 1'b0;
        st_next.sck   = 1'b1;
      end
    endcase

    // level interrupt from the updated flag and mask
    st_next.irq = st_next.flag && !st_next.mask;

    // read data stands for exactly one cycle
    st_next.rdata = 16'h0000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CSICS_OFS_IRQ_FLAGS: st_next.rdata[CSICS_FLAG_BIT] = st_reg.flag;
        CSICS_OFS_IRQ_MASK:  st_next.rdata[CSICS_MASK_BIT] = st_reg.mask;
        CSICS_OFS_START:     st_next.rdata = 16'h0000;
        CSICS_OFS_STATUS:    st_next.rdata[CSICS_TSF_BIT]  = st_reg.busy;
        CSICS_OFS_DATA:      st_next.rdata[7:0]            = st_reg.data;
        CSICS_OFS_ENABLE:    st_next.rdata[CSICS_START_BIT] = st_reg.op_en;
        default:             st_next.rdata = 16'h0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= '0;
      st_reg.phase    <= CSICS_IDLE;
      st_reg.mask     <= CSICS_MASK_RST;
      st_reg.data     <= CSICS_DATA_RST;
      st_reg.sck      <= 1'b1;
      st_reg.so       <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign rdata = st_reg.rdata;
  assign sck_o = st_reg.sck;
  assign so_o  = st_reg.so;
  assign irq_o = st_reg.irq;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence seq_start_write;
    clk_en && wr_start && bus_req.wdata[CSICS_START_BIT] && !wr_stop;
  endsequence

  sequence seq_frame_kick;
    clk_en && kick;
  endsequence

  sequence seq_frame_done;
    clk_en && done;
  endsequence

  // low half has run out: the next edge raises the clock and samples the peer
  sequence seq_rise_edge;
    clk_en && (st_reg.phase == CSICS_LOW) && (st_reg.half_cnt == 4'h0);
  endsequence

  // high half has run out inside the frame: the next edge lowers the clock
  sequence seq_fall_edge;
    clk_en && (st_reg.phase == CSICS_HIGH) && (st_reg.half_cnt == 4'h0) && !done;
  endsequence

  // a data write that lands while a frame is still shifting
  sequence seq_data_busy;
    clk_en && wr_data && st_reg.busy && !done;
  endsequence

  // a start trigger enables the channel
  chk_start_enables: assert property (seq_start_write |=> st_reg.op_en)
    else $error("start write did not set operation enable");

  // the start register is a pure trigger and reads zero
  chk_start_reads_zero: assert property (
    clk_en && bus_req.rd && bus_req.addr == CSICS_OFS_START |=> rdata == 16'h0000)
    else $error("start register read nonzero");

  // status bit 6 mirrors the transfer state
  chk_status_busy: assert property (
    clk_en && bus_req.rd && bus_req.addr == CSICS_OFS_STATUS
    |=> rdata[CSICS_TSF_BIT] == $past(st_reg.busy))
    else $error("status bit 6 does not show transfer state");

  // a kick lowers the clock and shows the top bit at once
  chk_kick_starts: assert property (
    seq_frame_kick |=> st_reg.busy && !sck_o && so_o == $past(bus_req.wdata[7]))
    else $error("data write did not start a frame");

  // frame end copies the received byte and raises the request
  chk_done_copies: assert property (
    seq_frame_done |=> st_reg.flag && !st_reg.busy && st_reg.data == $past(st_reg.shift))
    else $error("frame end did not copy data and raise request");

  // writing one clears the request when no frame ends in that cycle
  chk_flag_w1c: assert property (
    clk_en && wr_flags && bus_req.wdata[CSICS_FLAG_BIT] && !done |=> !st_reg.flag)
    else $error("request flag not cleared by writing one");

  // the interrupt never shows a masked or absent request
  chk_irq_gated: assert property (irq_o |-> st_reg.flag && !st_reg.mask)
    else $error("interrupt raised while masked or without request");

  // busy holds through the first low half at least
  chk_frame_length: assert property (
    seq_frame_kick ##1 clk_en [*8] |-> st_reg.busy)
    else $error("transfer dropped early");

  // the clock rests high outside a frame
  chk_sck_idle: assert property (!st_reg.busy |-> sck_o)
    else $error("serial clock not idle high outside a frame");

  // a zero in the start bit triggers nothing
  chk_start_zero_idle: assert property (
    clk_en && wr_start && !bus_req.wdata[CSICS_START_BIT]
    |=> st_reg.op_en == $past(st_reg.op_en))
    else $error("start write of zero changed operation enable");

  // the stop trigger drops operation enable
  chk_stop_clears: assert property (
    clk_en && wr_stop && bus_req.wdata[CSICS_START_BIT] |=> !st_reg.op_en)
    else $error("stop write left operation enable set");

  // the mask bit takes the written value
  chk_mask_takes: assert property (
    clk_en && wr_mask |=> st_reg.mask == $past(bus_req.wdata[CSICS_MASK_BIT]))
    else $error("mask bit did not take the written value");

  // a pending unmasked request always shows on the interrupt line
  chk_irq_follows: assert property (st_reg.flag && !st_reg.mask |-> irq_o)
    else $error("unmasked request not shown on the interrupt");

  // frame end beats a clear written in the same cycle
  chk_flag_set_wins: assert property (
    clk_en && done && wr_flags && bus_req.wdata[CSICS_FLAG_BIT] |=> st_reg.flag)
    else $error("clear at frame end lost the new request");

  // a data write during a frame leaves the held data byte unchanged
  chk_busy_drops_data: assert property (
    seq_data_busy |=> st_reg.data == $past(st_reg.data))
    else $error("data write during a frame was taken");

  // without operation enable a data write starts no frame
  chk_idle_no_start: assert property (
    clk_en && wr_data && !st_reg.op_en && !st_reg.busy |=> !st_reg.busy)
    else $error("frame started without operation enable");

  // read data stand one cycle and are zero otherwise
  chk_rdata_quiet: assert property (clk_en && !bus_req.rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");

  // inside a frame the serial clock only moves when a half period runs out
  chk_sck_hold: assert property (
    clk_en && st_reg.busy && (st_reg.half_cnt != 4'h0) |=> $stable(sck_o))
    else $error("serial clock moved inside a half period");

  // data out holds through the low half so the peer samples a settled bit
  chk_so_hold: assert property (
    clk_en && (st_reg.phase == CSICS_LOW) |=> $stable(so_o))
    else $error("data out changed while the clock was low");

  // each rising edge shifts the synchronised peer bit in at the bottom
  chk_rise_samples: assert property (
    seq_rise_edge |=> sck_o && (st_reg.shift[0] == $past(st_reg.si_sync)))
    else $error("rising edge did not sample the peer bit");

  // each falling edge inside the frame presents the next bit, msb first
  chk_fall_shifts: assert property (
    seq_fall_edge |=> !sck_o && (so_o == $past(st_reg.shift[7])))
    else $error("falling edge did not present the next bit");

  // counters stay inside one frame of eight bits
  chk_count_range: assert property (
    st_reg.busy
    |-> (st_reg.bit_cnt <= CSICS_FRAME_BITS) && (st_reg.half_cnt < CSICS_HALF_CYC))
    else $error("frame counters out of range");

  // status shows busy exactly while the shifter is away from idle
  chk_busy_phase: assert property (st_reg.busy == (st_reg.phase != CSICS_IDLE))
    else $error("busy flag disagrees with shifter phase");

  // data out rests high between frames
  chk_so_idle: assert property (!st_reg.busy |-> so_o)
    else $error("data out not high outside a frame");

  // a low clock enable freezes every flop
  chk_freeze: assert property (!clk_en |=> $stable(st_reg))
    else $error("state moved while clock enable was low");

  // frame end raises the interrupt unless the request is masked
  chk_done_irq: assert property (
    seq_frame_done |=> irq_o == !st_reg.mask)
    else $error("frame end interrupt does not follow the mask");

  // the flag register shows the request at bit 5, other bits zero
  chk_flags_read: assert property (
    clk_en && bus_req.rd && (bus_req.addr == CSICS_OFS_IRQ_FLAGS)
    |=> rdata == (16'($past(st_reg.flag)) << CSICS_FLAG_BIT))
    else $error("flag register read wrong");

  // the mask register shows the mask at bit 5, other bits zero
  chk_mask_read: assert property (
    clk_en && bus_req.rd && (bus_req.addr == CSICS_OFS_IRQ_MASK)
    |=> rdata == (16'($past(st_reg.mask)) << CSICS_MASK_BIT))
    else $error("mask register read wrong");

  // the data register shows its low byte, upper byte zero
  chk_data_read: assert property (
    clk_en && bus_req.rd && (bus_req.addr == CSICS_OFS_DATA)
    |=> rdata == {8'h00, $past(st_reg.data)})
    else $error("data register read wrong");

endmodule

`default_nettype wire

// ---- logic/csics_pkg.sv ----
/*
  shared constants and carrier types for the serial channel start and status block.
  assumes a 100 MHz core clock and a plain strobe register port with 3-bit register index.
*/
`default_nettype none

package csics_pkg;

  // register index map
  localparam logic [2:0] CSICS_OFS_IRQ_FLAGS = 3'h0; // irq_request_flags_high
  localparam logic [2:0] CSICS_OFS_IRQ_MASK  = 3'h1; // irq_mask_flags_high
  localparam logic [2:0] CSICS_OFS_START     = 3'h2; // channel_start_trigger
  localparam logic [2:0] CSICS_OFS_STATUS    = 3'h3; // channel_status
  localparam logic [2:0] CSICS_OFS_DATA      = 3'h4; // channel_data
  localparam logic [2:0] CSICS_OFS_STOP      = 3'h5; // channel stop trigger
  localparam logic [2:0] CSICS_OFS_ENABLE    = 3'h6; // channel operation-enable readback

  // field positions
  localparam int CSICS_FLAG_BIT  = 5; // transfer-end request flag
  localparam int CSICS_MASK_BIT  = 5; // transfer-end mask bit
  localparam int CSICS_START_BIT = 0; // channel 0 start / stop / enable bit
  localparam int CSICS_TSF_BIT   = 6; // transfer-in-progress flag

  // values after reset
  localparam logic       CSICS_MASK_RST = 1'b1;  // servicing blocked until software clears it
  localparam logic [7:0] CSICS_DATA_RST = 8'h00;

  // serial timing
  localparam int         CSICS_CORE_PERIOD_NS = 10;
  localparam int         CSICS_SCK_PERIOD_NS  = 160;
  localparam int         CSICS_HALF_CYC_INT   = (CSICS_SCK_PERIOD_NS / CSICS_CORE_PERIOD_NS) / 2;
  localparam logic [3:0] CSICS_HALF_CYC       = 4'(CSICS_HALF_CYC_INT);
  localparam logic [3:0] CSICS_FRAME_BITS     = 4'h8;

  // shifter phases, gray along idle -> low -> high
  typedef enum logic [1:0] {
    CSICS_IDLE = 2'b00,
    CSICS_LOW  = 2'b01,
    CSICS_HIGH = 2'b11
  } csics_phase_type;

  // register port request
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } csics_bus_req_type;

  // whole state of the block
  typedef struct packed {
    csics_phase_type phase;
    logic            op_en;
    logic            busy;
    logic            flag;
    logic            mask;
    logic [7:0]      data;
    logic [7:0]      shift;
    logic [3:0]      half_cnt;
    logic [3:0]      bit_cnt;
    logic            sck;
    logic            so;
    logic            irq;
    logic [15:0]     rdata;
    logic            si_meta;
    logic            si_sync;
  } csics_state_type;

endpackage

`default_nettype wire

// ---- tb/csics_peer.sv ----
/*
  behavioural serial peer: returns one byte on si and collects so, msb first.
  assumes the clock idles high, the master drives on falling and samples on rising edges.
*/
`default_nettype none
module csics_peer (
  input  wire logic       sck,     // serial clock from master
  input  wire logic       so,      // data from master
  output logic            si,      // data to master
  input  wire logic [7:0] tx_byte, // byte returned to master
  input  wire logic [7:0] lag_ns,  // delay of si after a falling edge
  output logic [7:0]      rx_byte  // byte collected from so
);
  timeunit 1ns;
  timeprecision 100ps;
  int   n_bit;
  logic in_frame;
  initial begin
    si = 1'b1;
    n_bit = 0;
    in_frame = 1'b0;
    rx_byte = 8'h00;
  end
  // present the next bit some time after each falling edge
  always @(negedge sck) begin
    in_frame = 1'b1;
    #(lag_ns) si = tx_byte[3'(7 - n_bit)];
  end
  // collect on rising edges; after the last bit si drifts so stale data never passes
  always @(posedge sck) begin
    if (in_frame) begin
      rx_byte = {rx_byte[6:0], so};
      n_bit = n_bit + 1;
      if (n_bit == 8) begin
        n_bit = 0;
        in_frame = 1'b0;
        #30 si = ~si;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/csi_channel_start_status_tb_top.sv ----
/*
  self-checking bench for the channel block: register port, interrupt and serial frames.
  assumes the peer model on the serial lines and a 100 MHz core clock.
*/
`default_nettype none
module csi_channel_start_status_tb_top
  import csics_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, arst_n, clk_en, sck, so, si, irq;
  csics_bus_req_type bus_req;
  logic [15:0] rdata;
  logic [7:0]  tx, pb, lag, prx;
  int n_mismatch, tests_run, cyc, m_flag, m_mask, m_op, m_busy, m_data, masked;

  csics_channel u_csics_channel (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
    .bus_req(bus_req), .rdata(rdata), .sck_o(sck), .so_o(so), .si_i(si), .irq_o(irq));
  csics_peer u_csics_peer (.sck(sck), .so(so), .si(si), .tx_byte(pb), .lag_ns(lag),
    .rx_byte(prx));

  // clock, and a cycle ceiling against hangs
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one strobe cycle; read data is looked at in the cycle after the strobe
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    #1;
  endtask
  // reference view of a register read
  function automatic logic [15:0] exp_reg(input logic [2:0] a);
    case (a)
      CSICS_OFS_IRQ_FLAGS: return 16'(m_flag * 32);
      CSICS_OFS_IRQ_MASK:  return 16'(m_mask * 32);
      CSICS_OFS_STATUS:    return 16'(m_busy * 64);
      CSICS_OFS_DATA:      return 16'(m_data);
      CSICS_OFS_ENABLE:    return 16'(m_op);
      default:             return 16'h0000;
    endcase
  endfunction
  task automatic rd_chk(input logic [2:0] a);
    bus(1'b0, a, 16'h0000);
    chk(rdata, exp_reg(a));
  endtask
  task automatic irq_chk();
    repeat (2) @(posedge core_clk);
    #1;
    chk({15'h0000, irq}, 16'(m_flag && !m_mask));
  endtask

  // main sequence
  initial begin
    bus_req = '0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    cyc = 0;
    {n_mismatch, tests_run, m_flag, m_busy, m_data, m_op} = '0;
    m_mask = 1;
    pb = 8'h00;
    lag = 8'h00;
    void'($urandom(23));
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    bus(1'b1, 3'h7, 16'hffff);
    bus(1'b1, CSICS_OFS_START, 16'h0000);
    for (int a = 0; a < 8; a++) rd_chk(3'(a));
    // clear the request, then unmask it, before starting
    bus(1'b1, CSICS_OFS_IRQ_FLAGS, 16'h0020);
    bus(1'b1, CSICS_OFS_IRQ_MASK, 16'h0000);
    m_mask = 0;
    bus(1'b1, CSICS_OFS_DATA, 16'h005a);
    m_data = 'h5a;
    rd_chk(CSICS_OFS_STATUS);
    rd_chk(CSICS_OFS_DATA);
    bus(1'b1, CSICS_OFS_START, 16'h0001);
    m_op = 1;
    rd_chk(CSICS_OFS_START);
    rd_chk(CSICS_OFS_ENABLE);
    // frames with random bytes, prompt and slow peer, one of them masked
    for (int i = 0; i < 4; i++) begin
      tx = 8'($urandom);
      pb = 8'($urandom);
      lag = (i % 2) ? 8'd40 : 8'd0;
      masked = (i == 2);
      bus(1'b1, CSICS_OFS_IRQ_MASK, 16'(masked * 32));
      m_mask = masked;
      bus(1'b1, CSICS_OFS_DATA, {8'($urandom), tx});
      m_busy = 1;
      rd_chk(CSICS_OFS_STATUS);
      bus(1'b1, CSICS_OFS_DATA, {8'h00, ~tx});
      repeat (122) @(posedge core_clk);
      bus(1'b1, CSICS_OFS_IRQ_FLAGS, 16'h0020); // clear meets the frame end, the set must win
      repeat (11) @(posedge core_clk);
      m_busy = 0;
      m_flag = 1;
      m_data = pb;
      irq_chk();
      chk({8'h00, prx}, {8'h00, tx});
      rd_chk(CSICS_OFS_DATA);
      rd_chk(CSICS_OFS_IRQ_FLAGS);
      rd_chk(CSICS_OFS_STATUS);
      if (masked) begin
        bus(1'b1, CSICS_OFS_IRQ_MASK, 16'h0000);
        m_mask = 0;
        irq_chk();
      end
      bus(1'b1, CSICS_OFS_IRQ_FLAGS, 16'h0020);
      m_flag = 0;
      irq_chk();
    end
    bus(1'b1, CSICS_OFS_STOP, 16'h0001);
    m_op = 0;
    rd_chk(CSICS_OFS_ENABLE);
    // frozen clock enable: a start write is not taken
    @(posedge core_clk);
    clk_en <= 1'b0;
    bus(1'b1, CSICS_OFS_START, 16'h0001);
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd_chk(CSICS_OFS_ENABLE);
    stop_test();
  end
endmodule
`default_nettype wire
